// ==== rtl/rbs_brake_stop.v ====
// Regenerative brake selection, duty tracking and stop method control.
// Assumes start and enable pins are asynchronous; bus is same-clock Avalon-MM.
`include "rbs_defs.vh"
module rbs_brake_stop #(
  parameter SEC_CYCLES = `RBS_SEC_CYCLES,
  parameter WIN_CYCLES = 1000
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire forward_start_input_in,
  input wire reverse_start_input_in,
  input wire operation_enable_input_in,
  input wire regen_converter_ready_n_in,
  input wire output_stop_input_in,
  input wire regen_active_in,
  input wire power_fail_stop_in,
  input wire panel_stop_in,
  input wire comm_err_stop_in,
  input wire jog_mode_in,
  input wire motor_stopped_in,
  output reg inverter_output_on_out,
  output reg decel_cmd_out,
  output reg start_from_fstart_out,
  output reg speed_search_out,
  output reg reverse_dir_out,
  output reg running_out,
  output reg brake_warning_display_out,
  output reg brake_duty_alarm_out,
  output reg regen_overvoltage_fault_out
);
  // ==================================================================
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN = 4'b0010;
  localparam [3:0] ST_DECEL = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;

  // ==================================================================
  // Input synchronisers
  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  wire fwd_s = sync2_q[0];
  wire rev_s = sync2_q[1];
  wire en_s = sync2_q[2];
  wire rdy_n_s = sync2_q[3];
  wire mrs_s = sync2_q[4];
  wire regen_s = sync2_q[5];
  wire stopped_s = sync2_q[6];
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {motor_stopped_in, regen_active_in, output_stop_input_in,
                  regen_converter_ready_n_in, operation_enable_input_in,
                  reverse_start_input_in, forward_start_input_in};
      sync2_q <= sync1_q;
    end
  end

  // ==================================================================
  // Settings registers
  reg [1:0] regen_sel_q;
  reg [4:0] duty_lim_q;
  reg [13:0] stop_sel_q;
  reg [7:0] ext_disp_q;
  reg [6:0] in_func_q;
  reg [6:0] out_func_q;
  reg rd_pend_q;
  wire [13:0] wd_stop = avs_writedata_in[13:0];
  wire stop_ok = (wd_stop <= `RBS_STOP_DLY_MAX) || (wd_stop == `RBS_STOP_DECEL_A) ||
                 (wd_stop == `RBS_STOP_DECEL_B) ||
                 (wd_stop >= `RBS_STOP_OFS && wd_stop <= `RBS_STOP_OFS_MAX);
  wire wr_unlock = (ext_disp_q == 8'h00);
  wire wr_hi_ok = (avs_writedata_in[31:14] == 18'h00000);
  // A write lands only at the edge where waitrequest is low
  wire wr = avs_write_in && avs_byteenable_in[0] && !avs_waitrequest_out;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      regen_sel_q <= `RBS_REGEN_SEL_RST;
      duty_lim_q <= `RBS_DUTY_LIM_RST;
      stop_sel_q <= `RBS_STOP_SEL_RST;
      ext_disp_q <= 8'h00;
      in_func_q <= `RBS_IN_FUNC_RST;
      out_func_q <= `RBS_OUT_FUNC_RST;
    end else if (wr) begin
      case (avs_address_in)
        `RBS_REG_REGEN_SEL: begin
          if (wr_unlock && wr_hi_ok && avs_writedata_in[13:0] <= 14'h0002) begin
            regen_sel_q <= avs_writedata_in[1:0];
          end
        end
        `RBS_REG_DUTY_LIM: begin
          if (wr_unlock && wr_hi_ok && avs_writedata_in[13:0] <= 14'h001e) begin
            duty_lim_q <= avs_writedata_in[4:0];
          end
        end
        `RBS_REG_STOP_SEL: begin
          if (wr_unlock && wr_hi_ok && stop_ok) begin
            stop_sel_q <= wd_stop;
          end
        end
        `RBS_REG_EXT_DISP: begin
          ext_disp_q <= avs_writedata_in[7:0];
        end
        `RBS_REG_IN_FUNC: begin
          if (wr_unlock) begin
            in_func_q <= avs_writedata_in[6:0];
          end
        end
        `RBS_REG_OUT_FUNC: begin
          if (wr_unlock) begin
            out_func_q <= avs_writedata_in[6:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==================================================================
  // Duty estimate over a fixed window
  reg [31:0] win_cnt_q;
  reg [31:0] on_cnt_q;
  reg [6:0] duty_pct_q;
  wire [4:0] eff_lim = (regen_sel_q == 2'h0) ? `RBS_FIXED_DUTY : duty_lim_q;
  wire [63:0] on_x100 = {32'h0, on_cnt_q} * 64'd100;
  wire [63:0] win_x = {32'h0, WIN_CYCLES[31:0]};
  // Percent of window spent regenerating, compared each tick
  wire [63:0] duty_x100w = on_x100;
  wire [63:0] lim_w = {59'h0, eff_lim} * win_x;
  wire reach_alarm = (duty_x100w * 64'd100 >= lim_w * `RBS_ALARM_PCT);
  wire reach_fault = (duty_x100w >= lim_w) && (lim_w != 64'h0);
  wire [63:0] duty_pct_w = on_x100 / win_x;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      win_cnt_q <= 32'h0;
      on_cnt_q <= 32'h0;
      duty_pct_q <= 7'h00;
    end else if (win_cnt_q >= WIN_CYCLES[31:0] - 32'h1) begin
      win_cnt_q <= 32'h0;
      on_cnt_q <= {31'h0, regen_s};
      duty_pct_q <= duty_pct_w[6:0];
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
      on_cnt_q <= on_cnt_q + {31'h0, regen_s};
    end
  end

  // ==================================================================
  // Alarm, warning and fault
  wire alarm_d = reach_alarm && (on_cnt_q != 32'h0);
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      brake_warning_display_out <= 1'b0;
      brake_duty_alarm_out <= 1'b0;
      regen_overvoltage_fault_out <= 1'b0;
    end else begin
      brake_warning_display_out <= alarm_d && (regen_sel_q != 2'h0);
      if (out_func_q == `RBS_OUT_FUNC_POS) begin
        brake_duty_alarm_out <= alarm_d;
      end else if (out_func_q == `RBS_OUT_FUNC_NEG) begin
        brake_duty_alarm_out <= ~alarm_d;
      end else begin
        brake_duty_alarm_out <= 1'b0;
      end
      if (reach_fault) begin
        regen_overvoltage_fault_out <= 1'b1;
      end
    end
  end

  // ==================================================================
  // Start decode and stop sequencer
  wire mode_sd = (stop_sel_q == `RBS_STOP_DECEL_B) ||
                 (stop_sel_q >= `RBS_STOP_OFS && stop_sel_q <= `RBS_STOP_OFS_MAX);
  wire start_req = mode_sd ? fwd_s : (fwd_s ^ rev_s);
  wire dir_rev = mode_sd ? rev_s : (rev_s && !fwd_s);
  wire decel_mode = (stop_sel_q == `RBS_STOP_DECEL_A) || (stop_sel_q == `RBS_STOP_DECEL_B) ||
                    power_fail_stop_in || panel_stop_in || comm_err_stop_in ||
                    jog_mode_in;
  // Stop requests that ramp down even with a start input held
  wire force_stop = power_fail_stop_in || panel_stop_in || comm_err_stop_in;
  wire [13:0] dly_s = (stop_sel_q >= `RBS_STOP_OFS) ? stop_sel_q - `RBS_STOP_OFS :
                      stop_sel_q;
  wire en_ok = (in_func_q == `RBS_IN_FUNC_ENABLE) ? en_s : 1'b1;
  // Alarm intentionally absent from the shut-off terms
  wire shut = !en_ok || rdy_n_s || mrs_s || regen_overvoltage_fault_out;
  reg [3:0] st_q;
  reg [31:0] tick_q;
  reg [13:0] sec_q;
  reg coast_q;
  reg rdy_seen_q;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= ST_IDLE;
      tick_q <= 32'h0;
      sec_q <= 14'h0;
      coast_q <= 1'b0;
      rdy_seen_q <= 1'b0;
      inverter_output_on_out <= 1'b0;
      decel_cmd_out <= 1'b0;
      start_from_fstart_out <= 1'b0;
      speed_search_out <= 1'b0;
      reverse_dir_out <= 1'b0;
      running_out <= 1'b0;
    end else begin
      start_from_fstart_out <= 1'b0;
      speed_search_out <= 1'b0;
      if (rdy_n_s) begin
        rdy_seen_q <= 1'b1;
      end
      if (stopped_s) begin
        coast_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          decel_cmd_out <= 1'b0;
          if (start_req && !shut) begin
            st_q <= ST_RUN;
            inverter_output_on_out <= 1'b1;
            running_out <= 1'b1;
            reverse_dir_out <= dir_rev;
            if (rdy_seen_q) begin
              speed_search_out <= 1'b1;
              rdy_seen_q <= 1'b0;
            end else begin
              start_from_fstart_out <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          reverse_dir_out <= dir_rev;
          if (!start_req || force_stop) begin
            tick_q <= 32'h0;
            sec_q <= 14'h0;
            if (decel_mode) begin
              st_q <= ST_DECEL;
              decel_cmd_out <= 1'b1;
            end else begin
              st_q <= ST_WAIT;
            end
          end
        end
        ST_DECEL: begin
          if (start_req && !force_stop) begin
            st_q <= ST_RUN;
            decel_cmd_out <= 1'b0;
          end else if (stopped_s) begin
            st_q <= ST_IDLE;
            decel_cmd_out <= 1'b0;
            inverter_output_on_out <= 1'b0;
            running_out <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (start_req) begin
            st_q <= ST_RUN;
          end else if (sec_q >= dly_s) begin
            st_q <= ST_IDLE;
            coast_q <= 1'b1;
            inverter_output_on_out <= 1'b0;
            running_out <= 1'b0;
          end else if (tick_q >= SEC_CYCLES - 1) begin
            tick_q <= 32'h0;
            sec_q <= sec_q + 14'h1;
          end else begin
            tick_q <= tick_q + 32'h1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      if (shut) begin
        st_q <= ST_IDLE;
        coast_q <= 1'b1;
        decel_cmd_out <= 1'b0;
        inverter_output_on_out <= 1'b0;
        running_out <= 1'b0;
      end
    end
  end

  // ==================================================================
  // Avalon-MM read path: one wait cycle on reads and one on writes
  wire [31:0] status = {26'h0, reverse_dir_out, regen_overvoltage_fault_out,
                        brake_duty_alarm_out, brake_warning_display_out, coast_q,
                        running_out};
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_pend_q <= 1'b0;
      avs_readdata_out <= 32'h0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      rd_pend_q <= avs_read_in && !rd_pend_q;
      avs_waitrequest_out <= !((avs_read_in && !rd_pend_q) ||
                               (avs_write_in && avs_waitrequest_out));
      if (avs_read_in && !rd_pend_q) begin
        case (avs_address_in)
          `RBS_REG_REGEN_SEL: avs_readdata_out <= {30'h0, regen_sel_q};
          `RBS_REG_DUTY_LIM: avs_readdata_out <= {27'h0, duty_lim_q};
          `RBS_REG_STOP_SEL: avs_readdata_out <= {18'h0, stop_sel_q};
          `RBS_REG_EXT_DISP: avs_readdata_out <= {24'h0, ext_disp_q};
          `RBS_REG_IN_FUNC: avs_readdata_out <= {25'h0, in_func_q};
          `RBS_REG_OUT_FUNC: avs_readdata_out <= {25'h0, out_func_q};
          `RBS_REG_STATUS: avs_readdata_out <= status;
          `RBS_REG_DUTY: avs_readdata_out <= {25'h0, duty_pct_q};
          default: avs_readdata_out <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ==== pkg/rbs_defs.vh ====
// Constants for the regenerative brake and stop control block.
// Assumes a 100 MHz clk_in and a 32-bit Avalon-MM register bus.
`ifndef RBS_DEFS_VH
`define RBS_DEFS_VH
// Register word offsets (byte addresses)
`define RBS_REG_REGEN_SEL 8'h00
`define RBS_REG_DUTY_LIM 8'h04
`define RBS_REG_STOP_SEL 8'h08
`define RBS_REG_EXT_DISP 8'h0c
`define RBS_REG_IN_FUNC 8'h10
`define RBS_REG_OUT_FUNC 8'h14
`define RBS_REG_STATUS 8'h18
`define RBS_REG_DUTY 8'h1c
// Reset values and codes
`define RBS_REGEN_SEL_RST 2'h0
`define RBS_REGEN_SEL_MAX 2'h2
`define RBS_DUTY_LIM_RST 5'h00
`define RBS_DUTY_LIM_MAX 5'h1e
`define RBS_FIXED_DUTY 5'h02
`define RBS_STOP_SEL_RST 14'h270f
`define RBS_STOP_DECEL_A 14'h270f
`define RBS_STOP_DECEL_B 14'h22b8
`define RBS_STOP_DLY_MAX 14'h0064
`define RBS_STOP_OFS 14'h03e8
`define RBS_STOP_OFS_MAX 14'h044c
`define RBS_IN_FUNC_ENABLE 7'h0a
`define RBS_OUT_FUNC_POS 7'h07
`define RBS_OUT_FUNC_NEG 7'h6b
`define RBS_IN_FUNC_RST 7'h00
`define RBS_OUT_FUNC_RST 7'h00
// Status bits
`define RBS_ST_RUN 0
`define RBS_ST_COAST 1
`define RBS_ST_WARN 2
`define RBS_ST_ALARM 3
`define RBS_ST_FAULT 4
`define RBS_ST_DIR 5
// Alarm and fault thresholds in percent of limit
`define RBS_ALARM_PCT 85
`define RBS_FAULT_PCT 100
// Timing
`define RBS_CLK_HZ 100000000
`define RBS_SEC_CYCLES (`RBS_CLK_HZ)
`endif

// ==== verif/rbs_brake_stop_chk.sv ====
// Port-level checks for the brake and stop block.
// Bound into rbs_brake_stop; one clock domain, synchronous reset.
module rbs_brake_stop_chk (
  input wire clk_in,
  input wire sys_rst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire regen_converter_ready_n_in,
  input wire output_stop_input_in,
  input wire panel_stop_in,
  input wire inverter_output_on_out,
  input wire decel_cmd_out,
  input wire start_from_fstart_out,
  input wire speed_search_out,
  input wire running_out,
  input wire regen_overvoltage_fault_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========
  // Assertions
  bus_answer_a: assert property ((avs_read_in || avs_write_in) |-> ##[0:4] !avs_waitrequest_out)
    else $error("bus request not answered");
  rdata_hold_a: assert property ((!avs_read_in && !$past(avs_read_in) && !$past(sys_rst_in))
    |-> $stable(avs_readdata_out)) else $error("read data moved without a read");
  conv_off_a: assert property (regen_converter_ready_n_in [*4] |=> !inverter_output_on_out)
    else $error("output on during converter fault");
  ostop_off_a: assert property (output_stop_input_in [*4] |=> !inverter_output_on_out)
    else $error("output on during output stop");
  run_drop_a: assert property (!inverter_output_on_out |-> !running_out)
    else $error("running shown with output off");
  fault_keep_a: assert property (regen_overvoltage_fault_out |=> regen_overvoltage_fault_out)
    else $error("overvoltage fault cleared without reset");
  fstart_pulse_a: assert property (start_from_fstart_out |=> !start_from_fstart_out)
    else $error("starting frequency pulse too long");
  search_pulse_a: assert property (speed_search_out |=> !speed_search_out)
    else $error("speed search pulse too long");
  stop_override_a: assert property ((panel_stop_in && inverter_output_on_out)
    |-> ##[0:3] (decel_cmd_out || !inverter_output_on_out)) else $error("panel stop ignored");
  // ==========
  // Covers
  cover property (speed_search_out);
  cover property ($fell(running_out));
  cover property ($rose(start_from_fstart_out));
  cover property (regen_overvoltage_fault_out);
endmodule

// ==== verif/rbs_conv_model.sv ====
// Behavioural regenerating converter at the block's far side.
// Assumes the bench drives its requests just after clk_in edges.
module rbs_conv_model (
  input wire clk_in,
  input wire mains_fail_in,
  input wire regen_req_in,
  output logic ready_n_out,
  output logic enable_out,
  output logic regen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ready_n_out = 1'b0;
    enable_out = 1'b1;
    regen_out = 1'b0;
  end
  always @(posedge clk_in) begin
    ready_n_out <= mains_fail_in;
    enable_out <= !mains_fail_in;
    regen_out <= regen_req_in;
  end
endmodule

// ==== verif/rbs_brake_stop_tb.sv ====
// Self-checking bench for rbs_brake_stop with the converter model.
// Assumes rbs_defs.vh on the include path; second and window counts scaled down.
`include "rbs_defs.vh"
module rbs_brake_stop_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;
  localparam int WIN = 100;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rv;
  logic wreq, rdy_n, ena, regen, on, dec, fst, srch, rdir, run, warn, alm, flt;
  logic fwd = 1'b0, rev = 1'b0, ostop = 1'b0, pstop = 1'b0, stp = 1'b0;
  logic mfail = 1'b0, regq = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  rbs_conv_model conv (.clk_in(clk_in), .mains_fail_in(mfail), .regen_req_in(regq),
    .ready_n_out(rdy_n), .enable_out(ena), .regen_out(regen));
  rbs_brake_stop #(.SEC_CYCLES(SEC), .WIN_CYCLES(WIN)) dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .forward_start_input_in(fwd), .reverse_start_input_in(rev),
    .operation_enable_input_in(ena), .regen_converter_ready_n_in(rdy_n),
    .output_stop_input_in(ostop), .regen_active_in(regen), .power_fail_stop_in(1'b0),
    .panel_stop_in(pstop), .comm_err_stop_in(1'b0), .jog_mode_in(1'b0),
    .motor_stopped_in(stp), .inverter_output_on_out(on), .decel_cmd_out(dec),
    .start_from_fstart_out(fst), .speed_search_out(srch), .reverse_dir_out(rdir),
    .running_out(run), .brake_warning_display_out(warn), .brake_duty_alarm_out(alm),
    .regen_overvoltage_fault_out(flt));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ==========
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_in);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50) chk(1'b1, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic do_reset;
    sys_rst_in <= 1'b1;
    tick(3);
    sys_rst_in <= 1'b0;
  endtask
  task automatic halt;
    stp <= 1'b1;
    tick(6);
    stp <= 1'b0;
  endtask
  task automatic run_stop(input logic [13:0] sel, input logic f, input logic r, input logic d);
    bus(1'b1, `RBS_REG_STOP_SEL, {18'h0, sel});
    fwd <= f;
    rev <= r;
    tick(10);
    chk({run, rdir}, {1'b1, d});
    fwd <= 1'b0;
    rev <= 1'b0;
    tick(6);
    chk(dec, 1'b1);
    halt();
  endtask
  task automatic coast(input logic [13:0] sel, input int dly);
    bus(1'b1, `RBS_REG_STOP_SEL, {18'h0, sel});
    fwd <= 1'b1;
    tick(10);
    fwd <= 1'b0;
    tick(3 + dly * SEC - 5);
    chk(on, 1'b1);
    tick(10);
    chk({on, run}, 2'b00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    tally_and_finish();
  end
  // ==========
  // Tests
  initial begin
    do_reset();
    rdc(`RBS_REG_REGEN_SEL, 32'h0);
    rdc(`RBS_REG_DUTY_LIM, 32'h0);
    rdc(`RBS_REG_STOP_SEL, 32'h270f);
    rdc(8'h20, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `RBS_REG_REGEN_SEL, i);
      rdc(`RBS_REG_REGEN_SEL, (i < 3) ? i : 2);
    end
    bus(1'b1, `RBS_REG_DUTY_LIM, 32'd30);
    bus(1'b1, `RBS_REG_DUTY_LIM, 32'd31);
    rdc(`RBS_REG_DUTY_LIM, 32'd30);
    bus(1'b1, `RBS_REG_EXT_DISP, 32'h1);
    bus(1'b1, `RBS_REG_STOP_SEL, 32'd5);
    rdc(`RBS_REG_STOP_SEL, 32'h270f);
    bus(1'b1, `RBS_REG_EXT_DISP, 32'h0);
    bus(1'b1, `RBS_REG_IN_FUNC, 32'd10);
    bus(1'b1, `RBS_REG_OUT_FUNC, 32'd7);
    run_stop(`RBS_STOP_DECEL_A, 1'b1, 1'b0, 1'b0);
    run_stop(`RBS_STOP_DECEL_A, 1'b0, 1'b1, 1'b1);
    run_stop(`RBS_STOP_DECEL_B, 1'b1, 1'b1, 1'b1);
    run_stop(`RBS_STOP_DECEL_B, 1'b1, 1'b0, 1'b0);
    coast(14'd100, 100);
    coast(14'd1100, 100);
    coast(14'd1002, 2);
    coast(14'd5, 5);
    fwd <= 1'b1;
    n = 0;
    while (fst !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(fst, 1'b1);
    tick(10);
    ostop <= 1'b1;
    tick(6);
    chk(on, 1'b0);
    ostop <= 1'b0;
    tick(10);
    pstop <= 1'b1;
    tick(4);
    chk(dec, 1'b1);
    pstop <= 1'b0;
    halt();
    tick(10);
    mfail <= 1'b1;
    tick(6);
    chk(on, 1'b0);
    mfail <= 1'b0;
    n = 0;
    while (srch !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(srch, 1'b1);
    bus(1'b1, `RBS_REG_REGEN_SEL, 32'd1);
    bus(1'b1, `RBS_REG_DUTY_LIM, 32'd10);
    regq <= 1'b1;
    n = 0;
    while (alm !== 1'b1 && n < 150) begin
      tick(1);
      n++;
    end
    chk({alm, warn, flt, on}, 4'b1101);
    tick(20);
    chk(flt, 1'b1);
    bus(1'b1, `RBS_REG_REGEN_SEL, 32'd2);
    bus(1'b1, `RBS_REG_DUTY_LIM, 32'd0);
    rdc(`RBS_REG_REGEN_SEL, 32'd2);
    rdc(`RBS_REG_DUTY_LIM, 32'd0);
    regq <= 1'b0;
    fwd <= 1'b0;
    do_reset();
    bus(1'b1, `RBS_REG_OUT_FUNC, 32'd107);
    tick(3);
    chk(alm, 1'b1);
    bus(1'b1, `RBS_REG_DUTY_LIM, 32'd30);
    regq <= 1'b1;
    tick(25);
    chk({warn, flt}, 2'b01);
    regq <= 1'b0;
    tally_and_finish();
  end
endmodule
bind rbs_brake_stop rbs_brake_stop_chk chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .regen_converter_ready_n_in(regen_converter_ready_n_in),
  .output_stop_input_in(output_stop_input_in), .panel_stop_in(panel_stop_in),
  .inverter_output_on_out(inverter_output_on_out), .decel_cmd_out(decel_cmd_out),
  .start_from_fstart_out(start_from_fstart_out), .speed_search_out(speed_search_out),
  .running_out(running_out), .regen_overvoltage_fault_out(regen_overvoltage_fault_out));
